/* hw/dmx_exec.sv */
// Decoder and executor for the data-move instruction group.
`timescale 1ns/1ns
module dmx_exec (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] instr,
    input  wire logic        instr_valid,
    input  wire logic [7:0]  mem_rdata,
    output dmx_pkg::dmx_phase_e phase_q,
    output logic      [11:0] mem_addr_q,
    output logic             mem_rd_q,
    output logic             mem_wr_q,
    output logic      [7:0]  mem_wdata_q,
    output logic      [7:0]  w_q,
    output logic      [7:0]  bank_select_reg_q,
    output logic             flag_n_q,
    output logic             flag_z_q,
    output logic             second_word_q
);

    dmx_pkg::dmx_state_e st_q;
    dmx_pkg::dmx_op_e    op_q;
    logic        [7:0]   lit_q;
    logic                dest_q;
    logic        [7:0]   data_q;

    dmx_pkg::dmx_state_e st_d;
    dmx_pkg::dmx_op_e    op_d;
    dmx_pkg::dmx_op_e    dec_op;
    logic        [11:0]  addr_d;
    logic        [11:0]  file_addr;
    logic        [3:0]   access_bank;
    logic                rd_d;
    logic                is_file;
    logic                is_mm;
    logic                is_lb;
    logic                is_lw;
    logic                addr_is_w;
    logic                wr_mem_d;
    logic                w_load;
    logic        [7:0]   w_val;

    dmx_phase_gen u_phase (
        .clk  (clk),
        .rst  (rst),
        .ph_q (phase_q)
    );

    // Opcode match on the word presented during Q1.
    assign is_file = instr[15:dmx_pkg::FILE_OPC_LSB] == dmx_pkg::FILE_OPC;
    assign is_mm   = instr[15:dmx_pkg::MM_OPC_LSB] == dmx_pkg::MM_OPC;
    assign is_lb   = instr[15:dmx_pkg::LIT_OPC_LSB] == dmx_pkg::LB_OPC;
    assign is_lw   = instr[15:dmx_pkg::LIT_OPC_LSB] == dmx_pkg::LW_OPC;
    assign dec_op  = !instr_valid ? dmx_pkg::OP_NONE   :
                     is_file      ? dmx_pkg::OP_FILE   :
                     is_mm        ? dmx_pkg::OP_MM_SRC :
                     is_lb        ? dmx_pkg::OP_LB     :
                     is_lw        ? dmx_pkg::OP_LW     : dmx_pkg::OP_NONE;

    // A second word always completes the memory-to-memory move.
    assign op_d = (st_q == dmx_pkg::ST_SECOND) ? dmx_pkg::OP_MM_DST : dec_op;
    assign st_d = (op_d == dmx_pkg::OP_MM_SRC) ? dmx_pkg::ST_SECOND
                                               : dmx_pkg::ST_ONE;

    // Banked file address: access bank when the access bit is clear.
    assign access_bank = (instr[7:0] < dmx_pkg::ACCESS_SPLIT)
                         ? dmx_pkg::ACCESS_LO_BNK : dmx_pkg::ACCESS_HI_BNK;
    assign file_addr   = instr[dmx_pkg::ACCESS_BIT]
                         ? {bank_select_reg_q[3:0], instr[7:0]}
                         : {access_bank, instr[7:0]};

    // Move operands use the full 12-bit field, ignoring the bank select.
    assign addr_d = (op_d == dmx_pkg::OP_FILE) ? file_addr
                                               : instr[11:0];
    assign rd_d   = (op_d == dmx_pkg::OP_FILE || op_d == dmx_pkg::OP_MM_SRC)
                    && (addr_d != dmx_pkg::WREG_ADDR);

    // Working register is served internally at its data-space address.
    assign addr_is_w = mem_addr_q == dmx_pkg::WREG_ADDR;

    // Memory write only for a move destination or a file write-back.
    assign wr_mem_d = ((op_q == dmx_pkg::OP_MM_DST)
                      || (op_q == dmx_pkg::OP_FILE && dest_q))
                      && !addr_is_w;

    // Working register loads: literal, move result, or move destination.
    assign w_load = (op_q == dmx_pkg::OP_LW)
                    || (op_q == dmx_pkg::OP_FILE && (!dest_q || addr_is_w))
                    || (op_q == dmx_pkg::OP_MM_DST && addr_is_w);
    assign w_val  = (op_q == dmx_pkg::OP_LW) ? lit_q : data_q;

    // Q1 decode, Q2 read, Q3 set up the write, Q4 write and retire.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q          <= dmx_pkg::ST_ONE;
            op_q          <= dmx_pkg::OP_NONE;
            lit_q         <= 8'h00;
            dest_q        <= 1'b0;
            data_q        <= 8'h00;
            mem_addr_q    <= 12'h000;
            mem_rd_q      <= 1'b0;
            mem_wr_q      <= 1'b0;
            mem_wdata_q   <= 8'h00;
            w_q           <= dmx_pkg::W_RESET;
            bank_select_reg_q <= dmx_pkg::BANK_RESET;
            flag_n_q      <= 1'b0;
            flag_z_q      <= 1'b0;
            second_word_q <= 1'b0;
        end else begin
            unique case (phase_q)
                dmx_pkg::PH_Q1: begin
                    st_q          <= st_d;
                    op_q          <= op_d;
                    lit_q         <= instr[7:0];
                    dest_q        <= instr[dmx_pkg::DEST_BIT];
                    mem_addr_q    <= addr_d;
                    mem_rd_q      <= rd_d;
                    second_word_q <= st_d == dmx_pkg::ST_SECOND;
                end
                dmx_pkg::PH_Q2: begin
                    mem_rd_q <= 1'b0;
                    if (op_q == dmx_pkg::OP_FILE
                        || op_q == dmx_pkg::OP_MM_SRC) begin
                        data_q <= addr_is_w ? w_q : mem_rdata;
                    end
                end
                dmx_pkg::PH_Q3: begin
                    mem_wr_q    <= wr_mem_d;
                    mem_wdata_q <= data_q;
                end
                dmx_pkg::PH_Q4: begin
                    mem_wr_q <= 1'b0;
                    if (w_load) begin
                        w_q <= w_val;
                    end
                    if (op_q == dmx_pkg::OP_LB) begin
                        bank_select_reg_q <= {dmx_pkg::BANK_UPPER,
                                              lit_q[3:0]};
                    end
                    // Only a file move touches the status flags.
                    if (op_q == dmx_pkg::OP_FILE) begin
                        flag_n_q <= data_q[7];
                        flag_z_q <= data_q == 8'h00;
                    end
                end
            endcase
        end
    end

    // Checks on the executed behaviour.
    AST_BANK_UPPER: assert property (@(posedge clk) disable iff (rst)
        bank_select_reg_q[7:4] == 4'h0)
        else $error("Bank select upper nibble not zero");

    AST_LB_LOAD: assert property (@(posedge clk) disable iff (rst)
        (phase_q == dmx_pkg::PH_Q1 && st_q == dmx_pkg::ST_ONE
         && instr_valid && is_lb)
        |-> ##4 bank_select_reg_q == {4'h0, $past(instr[3:0], 4)})
        else $error("Bank select literal not loaded");

    AST_LW_LOAD: assert property (@(posedge clk) disable iff (rst)
        (phase_q == dmx_pkg::PH_Q4 && op_q == dmx_pkg::OP_LW)
        |=> w_q == $past(lit_q) && $stable(flag_n_q) && $stable(flag_z_q))
        else $error("Literal not loaded into working register");

    AST_MM_SRC: assert property (@(posedge clk) disable iff (rst)
        (phase_q == dmx_pkg::PH_Q1 && st_q == dmx_pkg::ST_ONE
         && instr_valid && is_mm)
        |=> (mem_addr_q == $past(instr[11:0])) and (!mem_wr_q [*4]))
        else $error("Move source address wrong or source written");

    AST_MM_DST: assert property (@(posedge clk) disable iff (rst)
        (phase_q == dmx_pkg::PH_Q1 && st_q == dmx_pkg::ST_SECOND)
        |=> !mem_rd_q [*3] ##1 mem_addr_q == $past(instr[11:0], 4))
        else $error("Move destination address wrong or dummy read");

    AST_MM_WRITE: assert property (@(posedge clk) disable iff (rst)
        (phase_q == dmx_pkg::PH_Q4 && op_q == dmx_pkg::OP_MM_DST
         && !addr_is_w)
        |-> mem_wr_q && mem_wdata_q == data_q && $past(mem_wr_q, 3) == 1'b0)
        else $error("Move destination not written in last phase");

    AST_MM_WDST: assert property (@(posedge clk) disable iff (rst)
        (phase_q == dmx_pkg::PH_Q4 && op_q == dmx_pkg::OP_MM_DST
         && addr_is_w)
        |=> w_q == $past(data_q) && !$past(mem_wr_q))
        else $error("Move to working register failed");

    AST_FMOV_W: assert property (@(posedge clk) disable iff (rst)
        (phase_q == dmx_pkg::PH_Q4 && op_q == dmx_pkg::OP_FILE && !dest_q)
        |-> !mem_wr_q ##1 w_q == $past(data_q))
        else $error("File move to working register failed");

    AST_FMOV_F: assert property (@(posedge clk) disable iff (rst)
        (phase_q == dmx_pkg::PH_Q4 && op_q == dmx_pkg::OP_FILE && dest_q
         && !addr_is_w)
        |-> mem_wr_q && mem_wdata_q == data_q ##1 $stable(w_q))
        else $error("File move write-back failed");

    AST_FLAGS: assert property (@(posedge clk) disable iff (rst)
        (phase_q == dmx_pkg::PH_Q4 && (op_q == dmx_pkg::OP_LB
         || op_q == dmx_pkg::OP_MM_DST || op_q == dmx_pkg::OP_MM_SRC))
        |=> $stable(flag_n_q) && $stable(flag_z_q))
        else $error("Status flags changed by a move");

    AST_LIT_QUIET: assert property (@(posedge clk) disable iff (rst)
        (phase_q == dmx_pkg::PH_Q1 && st_q == dmx_pkg::ST_ONE
         && instr_valid && (is_lb || is_lw))
        |=> (!mem_rd_q && !mem_wr_q) [*4])
        else $error("Literal load touched data memory");

    AST_MM_PEND: assert property (@(posedge clk) disable iff (rst)
        (phase_q == dmx_pkg::PH_Q1 && st_q == dmx_pkg::ST_ONE
         && instr_valid && is_mm)
        |=> second_word_q [*4])
        else $error("Second word of a memory move not awaited");

endmodule // dmx_exec

/* hw/dmx_phase_gen.sv */
// Four-phase instruction cycle sequencer.
`timescale 1ns/1ns
module dmx_phase_gen (
    input  wire logic               clk,
    input  wire logic               rst,
    output dmx_pkg::dmx_phase_e     ph_q
);

    // Steps Q1, Q2, Q3, Q4 and wraps; reset restarts at Q1.
    always_ff @(posedge clk) begin
        if (rst) begin
            ph_q <= dmx_pkg::PH_Q1;
        end else begin
            unique case (ph_q)
                dmx_pkg::PH_Q1: ph_q <= dmx_pkg::PH_Q2;
                dmx_pkg::PH_Q2: ph_q <= dmx_pkg::PH_Q3;
                dmx_pkg::PH_Q3: ph_q <= dmx_pkg::PH_Q4;
                dmx_pkg::PH_Q4: ph_q <= dmx_pkg::PH_Q1;
            endcase
        end
    end

endmodule // dmx_phase_gen

/* hw/dmx_pkg.sv */
// Shared constants and types for the data-move instruction executor.
package dmx_pkg;

    // Four clock phases per instruction cycle, Gray coded in phase order.
    typedef enum logic [1:0] {
        PH_Q1 = 2'h0,
        PH_Q2 = 2'h1,
        PH_Q3 = 2'h3,
        PH_Q4 = 2'h2
    } dmx_phase_e;

    // Decoder sequencing: a single word, or waiting for a second word.
    typedef enum logic {
        ST_ONE    = 1'h0,
        ST_SECOND = 1'h1
    } dmx_state_e;

    // Operation carried through the current instruction cycle.
    typedef enum logic [2:0] {
        OP_NONE   = 3'h0,
        OP_FILE   = 3'h1,
        OP_MM_SRC = 3'h3,
        OP_MM_DST = 3'h2,
        OP_LB     = 3'h6,
        OP_LW     = 3'h7
    } dmx_op_e;

    // Opcode fields of the instruction word.
    localparam logic [5:0]  FILE_OPC      = 6'h14;
    localparam logic [3:0]  MM_OPC        = 4'hC;
    localparam logic [7:0]  LB_OPC        = 8'h01;
    localparam logic [7:0]  LW_OPC        = 8'h0E;
    localparam int          FILE_OPC_LSB  = 10;
    localparam int          MM_OPC_LSB    = 12;
    localparam int          LIT_OPC_LSB   = 8;
    localparam int          DEST_BIT      = 9;
    localparam int          ACCESS_BIT    = 8;

    // Data space layout.
    localparam logic [11:0] WREG_ADDR     = 12'hFE8;
    localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
    localparam logic [3:0]  ACCESS_LO_BNK = 4'h0;
    localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;
    localparam logic [3:0]  BANK_UPPER    = 4'h0;

    // Reset values.
    localparam logic [7:0]  W_RESET       = 8'h00;
    localparam logic [7:0]  BANK_RESET    = 8'h00;

endpackage : dmx_pkg

/* test/tb.sv */
// Self-checking testbench for the data-move instruction executor.
`timescale 1ns/1ns
module tb;
    logic                clk;
    logic                rst;
    logic [15:0]         instr;
    logic                instr_valid;
    logic [7:0]          mem_rdata;
    dmx_pkg::dmx_phase_e phase_q;
    logic [11:0]         mem_addr_q;
    logic                mem_rd_q;
    logic                mem_wr_q;
    logic [7:0]          mem_wdata_q;
    logic [7:0]          w_q;
    logic [7:0]          bank_select_reg_q;
    logic                flag_n_q;
    logic                flag_z_q;
    logic                second_word_q;
    logic [7:0]          mem [4096];
    int                  n_fail;
    int                  n_checks;
    int                  rd_cnt;
    int                  wr_cnt;

    dmx_exec dut (
        .clk               (clk),
        .rst               (rst),
        .instr             (instr),
        .instr_valid       (instr_valid),
        .mem_rdata         (mem_rdata),
        .phase_q           (phase_q),
        .mem_addr_q        (mem_addr_q),
        .mem_rd_q          (mem_rd_q),
        .mem_wr_q          (mem_wr_q),
        .mem_wdata_q       (mem_wdata_q),
        .w_q               (w_q),
        .bank_select_reg_q (bank_select_reg_q),
        .flag_n_q          (flag_n_q),
        .flag_z_q          (flag_z_q),
        .second_word_q     (second_word_q)
    );

    // Data memory: read data is inverted while no read strobe stands.
    assign mem_rdata = mem_rd_q ? mem[mem_addr_q] : ~mem[mem_addr_q];

    // Memory takes a write at the edge that ends the write strobe.
    always @(posedge clk) begin
        if (mem_wr_q === 1'b1) mem[mem_addr_q] <= mem_wdata_q;
    end

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                       input string m);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask

    // Issues one word at the next Q1 and counts strobes over its cycle.
    task automatic run(input logic [15:0] word, input logic vld);
        int k;
        k = 0;
        while (phase_q !== dmx_pkg::PH_Q1 && k < 8) begin
            @(posedge clk);
            #1 k++;
        end
        if (k == 8) begin
            chk(12'h0, 12'h1, "phase never reached Q1");
            report_and_stop();
        end
        instr = word;
        instr_valid = vld;
        rd_cnt = 0;
        wr_cnt = 0;
        repeat (4) begin
            @(posedge clk);
            #1 instr_valid = 1'b0;
            if (mem_rd_q === 1'b1) rd_cnt++;
            if (mem_wr_q === 1'b1) wr_cnt++;
            if (mem_wr_q === 1'b1) begin
                chk(12'(phase_q), 12'h2, "write not in Q4");
            end
        end
    endtask

    task automatic chk_flags(input logic n, input logic z);
        chk({11'h0, flag_n_q}, {11'h0, n}, "negative flag");
        chk({11'h0, flag_z_q}, {11'h0, z}, "zero flag");
    endtask

    task automatic test_file_move();
        mem[12'h010] = 8'h22;
        run(16'h5010, 1'b1);
        chk({4'h0, w_q}, 12'h022, "file move to W");
        chk(12'(wr_cnt), 12'h0, "file move to W wrote memory");
        chk_flags(1'b0, 1'b0);
        mem[12'hF61] = 8'h80;
        run(16'h5261, 1'b1);
        chk(12'(wr_cnt), 12'h1, "file move back strobe");
        chk({4'h0, mem[12'hF61]}, 12'h080, "file move back data");
        chk({4'h0, w_q}, 12'h022, "W changed by write back");
        chk_flags(1'b1, 1'b0);
        $display("test file_move done");
    endtask

    task automatic test_literals();
        logic [7:0] ks [3];
        ks = '{8'hF5, 8'h3A, 8'hFF};
        foreach (ks[i]) begin
            run({8'h01, ks[i]}, 1'b1);
            chk({4'h0, bank_select_reg_q}, {8'h0, ks[i][3:0]},
                "bank literal");
            chk(12'(rd_cnt + wr_cnt), 12'h0, "bank literal strobes");
            chk_flags(1'b1, 1'b0);
        end
        foreach (ks[i]) begin
            run({8'h0E, ks[i]}, 1'b1);
            chk({4'h0, w_q}, {4'h0, ks[i]}, "work literal");
            chk_flags(1'b1, 1'b0);
        end
        run(16'h013A, 1'b1);
        mem[12'hA20] = 8'h00;
        mem[12'h020] = 8'h77;
        run(16'h5120, 1'b1);
        chk({4'h0, w_q}, 12'h000, "banked file move");
        chk_flags(1'b0, 1'b1);
        $display("test literals done");
    endtask

    // Destinations avoid the program counter and stack top bytes.
    task automatic test_mem_move();
        mem[12'hABC] = 8'h33;
        mem[12'h123] = 8'h11;
        run(16'hCABC, 1'b1);
        chk({11'h0, second_word_q}, 12'h1, "second word pending");
        chk(12'(rd_cnt), 12'h1, "source read count");
        chk(12'(wr_cnt), 12'h0, "write in first cycle");
        run(16'hF123, 1'b0);
        chk(12'(rd_cnt), 12'h0, "dummy read");
        chk(12'(wr_cnt), 12'h1, "destination write");
        chk({4'h0, mem[12'h123]}, 12'h033, "destination");
        chk({4'h0, mem[12'hABC]}, 12'h033, "source kept");
        chk({11'h0, second_word_q}, 12'h0, "second word cleared");
        chk_flags(1'b0, 1'b1);
        run(16'h0E5A, 1'b1);
        run(16'hCFE8, 1'b1);
        run(16'h00FF, 1'b1);
        chk({4'h0, mem[12'h0FF]}, 12'h05A, "W as source");
        run(16'hC123, 1'b1);
        run(16'hFFE8, 1'b1);
        chk({4'h0, w_q}, 12'h033, "W as destination");
        chk({4'h0, bank_select_reg_q}, 12'h00A, "bank changed by move");
        chk_flags(1'b0, 1'b1);
        run(16'h52E8, 1'b1);
        chk({4'h0, w_q}, 12'h033, "file move of W");
        chk(12'(rd_cnt + wr_cnt), 12'h0, "file move of W strobes");
        chk_flags(1'b0, 1'b0);
        $display("test mem_move done");
    endtask

    task automatic test_refused();
        run(16'h0E77, 1'b0);
        chk({4'h0, w_q}, 12'h033, "invalid word executed");
        run(16'hFFFF, 1'b1);
        chk(12'(rd_cnt + wr_cnt), 12'h0, "unknown opcode strobes");
        chk({bank_select_reg_q, w_q[3:0]}, 12'h0A3,
            "unknown opcode changed state");
        $display("test refused done");
    endtask

    // Bounded run time.
    initial begin
        repeat (20000) @(posedge clk);
        chk(12'h0, 12'h1, "timeout");
        report_and_stop();
    end

    // Main sequence.
    initial begin
        rst = 1'b1;
        instr = 16'h0000;
        instr_valid = 1'b0;
        n_fail = 0;
        n_checks = 0;
        for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        chk({bank_select_reg_q, w_q[3:0]}, 12'h000, "reset registers");
        chk(12'(phase_q), 12'h0, "reset phase");
        test_file_move();
        test_literals();
        test_mem_move();
        test_refused();
        report_and_stop();
    end
endmodule // tb
